/* File: pkg/rbs_pkg.sv */
// constants and types shared by the reversal brake and input select block
//
// Contract
// - while changing between forward and reverse, DC braking starts once output frequency drops below the reversal stop frequency.
// - the reversal stop frequency setting spans 0.5 Hz to 60.0 Hz and is the threshold where reversal braking begins.
// - the reversal brake duration spans 0.1 s to 120.0 s, and a setting of 0000 disables reversal braking.
// - the reversal brake strength spans 0 to 100 in steps of 5, a larger value braking harder.
// - the reversal stop frequency matters only while the reversal brake duration is nonzero.
// - braking at an ordinary stop uses its own stop frequency, duration and level, apart from the reversal set.
// - each of the five switch inputs takes a function by select code: 0 multi-speed up to 7 frequency source switch.
// - codes 8 second characteristic, 9 PID cancel, 10 three-wire stop, 12 speed search, 13 winding pause serve every input.
// - in sixteen-speed operation with all five inputs on multi-speed, only the four lowest inputs form the speed code.
// - after a trip the outside party turns the reset input on then off, and the trip clears on the off edge.
package rbs_pkg;

    localparam int NUM_SW = 5;
    localparam int SEL_W  = 4;

    // frequency in 0.1 Hz, time in 0.1 s, level in percent
    localparam int FREQ_W  = 10;
    localparam int TIME_W  = 11;
    localparam int LEVEL_W = 7;

    localparam logic [FREQ_W-1:0]  FREQ_MIN   = 10'h005;
    localparam logic [FREQ_W-1:0]  FREQ_MAX   = 10'h258;
    localparam logic [TIME_W-1:0]  TIME_OFF   = 11'h000;
    localparam logic [TIME_W-1:0]  TIME_MAX   = 11'h4B0;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX  = 7'h64;
    localparam logic [LEVEL_W-1:0] LEVEL_STEP = 7'h05;

    // brake time resolution, derived to clock cycles
    localparam int CLK_FREQ_HZ       = 100_000_000;
    localparam int BRAKE_TICK_MS     = 100;
    localparam int BRAKE_TICK_CYCLES = BRAKE_TICK_MS * (CLK_FREQ_HZ / 1000);

    // switch function codes
    localparam logic [SEL_W-1:0] FN_MULTISPEED = 4'h0;
    localparam logic [SEL_W-1:0] FN_RESET      = 4'h1;
    localparam logic [SEL_W-1:0] FN_RESET_LOCK = 4'h2;
    localparam logic [SEL_W-1:0] FN_INCHING    = 4'h3;
    localparam logic [SEL_W-1:0] FN_EXT_FAULT  = 4'h4;
    localparam logic [SEL_W-1:0] FN_PARAM_LOCK = 4'h5;
    localparam logic [SEL_W-1:0] FN_COAST      = 4'h6;
    localparam logic [SEL_W-1:0] FN_FREQ_SRC   = 4'h7;
    localparam logic [SEL_W-1:0] FN_SECOND_SET = 4'h8;
    localparam logic [SEL_W-1:0] FN_PID_CANCEL = 4'h9;
    localparam logic [SEL_W-1:0] FN_THREE_WIRE = 4'hA;
    localparam logic [SEL_W-1:0] FN_PULSE_UPDN = 4'hB;
    localparam logic [SEL_W-1:0] FN_SPEED_SRCH = 4'hC;
    localparam logic [SEL_W-1:0] FN_WIND_PAUSE = 4'hD;
    localparam logic [SEL_W-1:0] FN_WIND_LEN   = 4'hE;

    // multi-speed mode code that means sixteen speeds
    localparam int               MS_MODE_W       = 3;
    localparam logic [MS_MODE_W-1:0] MS_MODE_SIXTEEN = 3'h1;

    typedef enum logic [3:0] {
        BR_IDLE = 4'b0001,
        BR_REV  = 4'b0010,
        BR_STOP = 4'b0100,
        BR_HOLD = 4'b1000
    } rbs_brake_state_type;

endpackage

/* File: rtl/rbs_input_sync.sv */
// two-stage synchroniser for the switch terminals
`timescale 1ns/1ps
`default_nettype none
module rbs_input_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // pins and synchronised levels
    input  wire logic [WIDTH-1:0] d_async,
    output logic      [WIDTH-1:0] d_sync
);
    logic [WIDTH-1:0] meta_reg;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("rbs_input_sync needs WIDTH of at least 1");
        end
    endgenerate

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            d_sync   <= '0;
        end else begin
            meta_reg <= d_async;
            d_sync   <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/rbs_brake_timer.sv */
// brake duration counter in 0.1 s ticks
`timescale 1ns/1ps
`default_nettype none
module rbs_brake_timer
    import rbs_pkg::*;
#(
    parameter int TICK_CYCLES = BRAKE_TICK_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // control
    input  wire logic              start,
    input  wire logic              abort,
    input  wire logic [TIME_W-1:0] load,
    // status
    output logic                   busy,
    output logic                   done
);
    localparam int DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    logic [DIV_W-1:0]  div_reg;
    logic [TIME_W-1:0] remain_reg;

    generate
        if (TICK_CYCLES < 1) begin : g_bad_tick
            $error("rbs_brake_timer needs TICK_CYCLES of at least 1");
        end
    endgenerate

    // a zero load never reaches here: the caller treats zero as disabled
    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg    <= '0;
            remain_reg <= '0;
            busy       <= 1'b0;
            done       <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                div_reg    <= '0;
                remain_reg <= load;
                busy       <= 1'b1;
            end else if (busy) begin
                if (div_reg == DIV_LAST) begin
                    div_reg    <= '0;
                    remain_reg <= remain_reg - 1'b1;
                    if (remain_reg == 11'h001) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end else begin
                    div_reg <= div_reg + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/rbs_reversal_brake_top.sv */
// reversal and stop DC brake sequencing plus switch input function select
`timescale 1ns/1ps
`default_nettype none
module rbs_reversal_brake_top
    import rbs_pkg::*;
#(
    parameter int TICK_CYCLES = BRAKE_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 SYS_RST,
    // switch terminals
    input  wire logic                 SWITCH_INPUT_1,
    input  wire logic                 SWITCH_INPUT_2,
    input  wire logic                 SWITCH_INPUT_3,
    input  wire logic                 SWITCH_INPUT_4,
    input  wire logic                 SWITCH_INPUT_5,
    // switch function settings
    input  wire logic [SEL_W-1:0]     INPUT1_FUNCTION_SELECT,
    input  wire logic [SEL_W-1:0]     INPUT2_FUNCTION_SELECT,
    input  wire logic [SEL_W-1:0]     INPUT3_FUNCTION_SELECT,
    input  wire logic [SEL_W-1:0]     INPUT4_FUNCTION_SELECT,
    input  wire logic [SEL_W-1:0]     INPUT5_FUNCTION_SELECT,
    input  wire logic [MS_MODE_W-1:0] MULTISPEED_MODE_SELECT,
    // brake settings
    input  wire logic [FREQ_W-1:0]    REVERSAL_STOP_FREQ,
    input  wire logic [TIME_W-1:0]    REVERSAL_BRAKE_TIME,
    input  wire logic [LEVEL_W-1:0]   REVERSAL_BRAKE_LEVEL,
    input  wire logic [FREQ_W-1:0]    NORMAL_STOP_FREQ,
    input  wire logic [TIME_W-1:0]    NORMAL_BRAKE_TIME,
    input  wire logic [LEVEL_W-1:0]   NORMAL_BRAKE_LEVEL,
    // drive status
    input  wire logic [FREQ_W-1:0]    OUTPUT_FREQ,
    input  wire logic                 REVERSING,
    input  wire logic                 RAMP_STOPPING,
    input  wire logic                 FAULT_EVENT,
    // brake outputs
    output logic                      DC_BRAKE_ACTIVE,
    output logic                      REVERSAL_BRAKE_ACTIVE,
    output logic [LEVEL_W-1:0]        DC_BRAKE_LEVEL,
    output logic                      BRAKE_DONE,
    // fault state
    output logic                      FAULT_TRIPPED,
    // switch functions
    output logic [NUM_SW-1:0]         SPEED_CODE,
    output logic                      RESET_LOCK_ACTIVE,
    output logic                      INCHING_SELECT,
    output logic                      EXT_FAULT_STOP,
    output logic                      PARAM_LOCK,
    output logic                      COAST_STOP,
    output logic                      FREQ_SOURCE_2ND,
    output logic                      SECOND_CHAR_SET,
    output logic                      PID_CANCEL,
    output logic                      THREE_WIRE_STOP,
    output logic                      SPEED_SEARCH,
    output logic                      WINDING_PAUSE,
    output logic                      PULSE_COUNT_IN,
    output logic                      FREQ_UP_DOWN,
    output logic                      WIND_LEN_MODE,
    output logic                      WIND_LEN_CLEAR
);
    // which inputs carry a given function code
    function automatic logic [NUM_SW-1:0] fn_hits(input logic [NUM_SW*SEL_W-1:0] sels,
                                                  input logic [SEL_W-1:0]        code);
        logic [NUM_SW-1:0] hits;
        hits = '0;
        for (int i = 0; i < NUM_SW; i++) begin
            hits[i] = (sels[i*SEL_W +: SEL_W] == code);
        end
        return hits;
    endfunction

    // clamp a frequency setting to its legal span
    function automatic logic [FREQ_W-1:0] clamp_freq(input logic [FREQ_W-1:0] f);
        logic [FREQ_W-1:0] r;
        r = f;
        if (f < FREQ_MIN) begin
            r = FREQ_MIN;
        end else if (f > FREQ_MAX) begin
            r = FREQ_MAX;
        end
        return r;
    endfunction

    function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] t);
        return (t > TIME_MAX) ? TIME_MAX : t;
    endfunction

    // levels cap at the maximum and snap down to the step grid
    function automatic logic [LEVEL_W-1:0] clamp_level(input logic [LEVEL_W-1:0] l);
        logic [LEVEL_W-1:0] c;
        c = (l > LEVEL_MAX) ? LEVEL_MAX : l;
        return c - LEVEL_W'(c % LEVEL_STEP);
    endfunction

    logic [NUM_SW-1:0]        sw_pins;
    logic [NUM_SW-1:0]        sw_sync;
    logic [NUM_SW*SEL_W-1:0]  sel_flat;
    logic [FREQ_W-1:0]        rev_freq_eff;
    logic [FREQ_W-1:0]        norm_freq_eff;
    logic [TIME_W-1:0]        rev_time_eff;
    logic [TIME_W-1:0]        norm_time_eff;
    logic [LEVEL_W-1:0]       rev_level_eff;
    logic [LEVEL_W-1:0]       norm_level_eff;
    logic                     rev_go;
    logic                     stop_go;
    logic                     timer_start;
    logic                     timer_abort;
    logic                     timer_busy;
    logic                     timer_done;
    rbs_brake_state_type      state_reg;
    rbs_brake_state_type      state_next;
    logic [NUM_SW-1:0]        ms_mask;
    logic [NUM_SW-1:0]        speed_next;
    logic                     reset_level;
    logic                     reset_prev_reg;
    logic                     reset_armed_reg;
    logic                     trip_set;
    logic                     trip_clear;

    assign sw_pins  = {SWITCH_INPUT_5, SWITCH_INPUT_4, SWITCH_INPUT_3,
                       SWITCH_INPUT_2, SWITCH_INPUT_1};
    assign sel_flat = {INPUT5_FUNCTION_SELECT, INPUT4_FUNCTION_SELECT, INPUT3_FUNCTION_SELECT,
                       INPUT2_FUNCTION_SELECT, INPUT1_FUNCTION_SELECT};

    rbs_input_sync #(
        .WIDTH (NUM_SW)
    ) u_sync (
        .clk     (CLK),
        .rst     (SYS_RST),
        .d_async (sw_pins),
        .d_sync  (sw_sync)
    );

    // settings outside their span are clamped rather than refused
    assign rev_freq_eff   = clamp_freq(REVERSAL_STOP_FREQ);
    assign norm_freq_eff  = clamp_freq(NORMAL_STOP_FREQ);
    assign rev_time_eff   = clamp_time(REVERSAL_BRAKE_TIME);
    assign norm_time_eff  = clamp_time(NORMAL_BRAKE_TIME);
    assign rev_level_eff  = clamp_level(REVERSAL_BRAKE_LEVEL);
    assign norm_level_eff = clamp_level(NORMAL_BRAKE_LEVEL);

    // threshold is looked at only when the duration is not 0000
    assign rev_go  = REVERSING && (rev_time_eff != TIME_OFF)
                     && (OUTPUT_FREQ < rev_freq_eff);
    // ordinary stop braking uses its own set of settings
    assign stop_go = !REVERSING && RAMP_STOPPING && (norm_time_eff != TIME_OFF)
                     && (OUTPUT_FREQ < norm_freq_eff);

    always_comb begin
        state_next  = state_reg;
        timer_start = 1'b0;
        timer_abort = 1'b0;
        unique case (state_reg)
            BR_IDLE: begin
                if (rev_go) begin
                    state_next  = BR_REV;
                    timer_start = 1'b1;
                end else if (stop_go) begin
                    state_next  = BR_STOP;
                    timer_start = 1'b1;
                end
            end
            BR_REV: begin
                if (!REVERSING) begin
                    state_next  = BR_IDLE;
                    timer_abort = 1'b1;
                end else if (timer_done) begin
                    state_next = BR_HOLD;
                end
            end
            BR_STOP: begin
                if (!RAMP_STOPPING) begin
                    state_next  = BR_IDLE;
                    timer_abort = 1'b1;
                end else if (timer_done) begin
                    state_next = BR_HOLD;
                end
            end
            // hold off re-braking until the drive leaves the reversal or stop
            BR_HOLD: begin
                if (!REVERSING && !RAMP_STOPPING) begin
                    state_next = BR_IDLE;
                end
            end
            default: begin
                state_next  = BR_IDLE;
                timer_abort = 1'b1;
            end
        endcase
    end

    rbs_brake_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk   (CLK),
        .rst   (SYS_RST),
        .start (timer_start),
        .abort (timer_abort),
        .load  (rev_go ? rev_time_eff : norm_time_eff),
        .busy  (timer_busy),
        .done  (timer_done)
    );

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg             <= BR_IDLE;
            DC_BRAKE_ACTIVE       <= 1'b0;
            REVERSAL_BRAKE_ACTIVE <= 1'b0;
            DC_BRAKE_LEVEL        <= '0;
            BRAKE_DONE            <= 1'b0;
        end else begin
            state_reg             <= state_next;
            DC_BRAKE_ACTIVE       <= (state_next == BR_REV) || (state_next == BR_STOP);
            REVERSAL_BRAKE_ACTIVE <= (state_next == BR_REV);
            BRAKE_DONE            <= timer_done;
            if (timer_start) begin
                // level latched at brake start so a mid-brake edit cannot jolt the motor
                DC_BRAKE_LEVEL <= rev_go ? rev_level_eff : norm_level_eff;
            end else if (state_next == BR_IDLE || state_next == BR_HOLD) begin
                DC_BRAKE_LEVEL <= '0;
            end
        end
    end

    // speed code: in sixteen-speed mode with all five inputs on multi-speed the fifth input drops out
    assign ms_mask = fn_hits(sel_flat, FN_MULTISPEED);
    always_comb begin
        speed_next = sw_sync & ms_mask;
        if (MULTISPEED_MODE_SELECT == MS_MODE_SIXTEEN && (&ms_mask)) begin
            speed_next[NUM_SW-1] = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SPEED_CODE        <= '0;
            RESET_LOCK_ACTIVE <= 1'b0;
            INCHING_SELECT    <= 1'b0;
            EXT_FAULT_STOP    <= 1'b0;
            PARAM_LOCK        <= 1'b0;
            COAST_STOP        <= 1'b0;
            FREQ_SOURCE_2ND   <= 1'b0;
            SECOND_CHAR_SET   <= 1'b0;
            PID_CANCEL        <= 1'b0;
            THREE_WIRE_STOP   <= 1'b0;
            SPEED_SEARCH      <= 1'b0;
            WINDING_PAUSE     <= 1'b0;
            PULSE_COUNT_IN    <= 1'b0;
            FREQ_UP_DOWN      <= 1'b0;
            WIND_LEN_MODE     <= 1'b0;
            WIND_LEN_CLEAR    <= 1'b0;
        end else begin
            SPEED_CODE        <= speed_next;
            RESET_LOCK_ACTIVE <= |(sw_sync & fn_hits(sel_flat, FN_RESET_LOCK));
            INCHING_SELECT    <= |(sw_sync & fn_hits(sel_flat, FN_INCHING));
            EXT_FAULT_STOP    <= |(sw_sync & fn_hits(sel_flat, FN_EXT_FAULT));
            PARAM_LOCK        <= |(sw_sync & fn_hits(sel_flat, FN_PARAM_LOCK));
            COAST_STOP        <= |(sw_sync & fn_hits(sel_flat, FN_COAST));
            FREQ_SOURCE_2ND   <= |(sw_sync & fn_hits(sel_flat, FN_FREQ_SRC));
            SECOND_CHAR_SET   <= |(sw_sync & fn_hits(sel_flat, FN_SECOND_SET));
            PID_CANCEL        <= |(sw_sync & fn_hits(sel_flat, FN_PID_CANCEL));
            THREE_WIRE_STOP   <= |(sw_sync & fn_hits(sel_flat, FN_THREE_WIRE));
            SPEED_SEARCH      <= |(sw_sync & fn_hits(sel_flat, FN_SPEED_SRCH));
            WINDING_PAUSE     <= |(sw_sync & fn_hits(sel_flat, FN_WIND_PAUSE));
            // input-specific codes: other inputs set to them do nothing
            PULSE_COUNT_IN    <= sw_sync[1] & (INPUT2_FUNCTION_SELECT == FN_PULSE_UPDN);
            FREQ_UP_DOWN      <= sw_sync[4] & (INPUT5_FUNCTION_SELECT == FN_PULSE_UPDN);
            WIND_LEN_MODE     <= sw_sync[0] & (INPUT1_FUNCTION_SELECT == FN_WIND_LEN);
            WIND_LEN_CLEAR    <= sw_sync[2] & (INPUT3_FUNCTION_SELECT == FN_WIND_LEN);
        end
    end

    // fault trip: reset must be seen on while tripped, then cleared on its fall
    assign reset_level = |(sw_sync & fn_hits(sel_flat, FN_RESET));
    assign trip_set    = FAULT_EVENT || EXT_FAULT_STOP;
    assign trip_clear  = FAULT_TRIPPED && reset_armed_reg && reset_prev_reg && !reset_level;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            FAULT_TRIPPED   <= 1'b0;
            reset_prev_reg  <= 1'b0;
            reset_armed_reg <= 1'b0;
        end else begin
            reset_prev_reg <= reset_level;
            if (trip_set) begin
                FAULT_TRIPPED <= 1'b1;                         // set wins over clear
            end else if (trip_clear) begin
                FAULT_TRIPPED <= 1'b0;
            end
            if (!FAULT_TRIPPED || trip_clear) begin
                reset_armed_reg <= 1'b0;
            end else if (reset_level) begin
                reset_armed_reg <= 1'b1;
            end
        end
    end

    a_rev_brake_start: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_reg == BR_IDLE && rev_go) |=> (REVERSAL_BRAKE_ACTIVE && DC_BRAKE_ACTIVE))
        else $error("reversal brake did not start below threshold");
    a_rev_freq_span: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_reg == BR_IDLE && REVERSING && REVERSAL_BRAKE_TIME != TIME_OFF
         && OUTPUT_FREQ >= FREQ_MAX) |=> !REVERSAL_BRAKE_ACTIVE)
        else $error("reversal brake started above the top threshold");
    a_rev_time_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        (REVERSAL_BRAKE_TIME == TIME_OFF && state_reg == BR_IDLE) |=> !REVERSAL_BRAKE_ACTIVE)
        else $error("reversal brake ran with duration 0000");
    a_level_grid: assert property (@(posedge CLK) disable iff (SYS_RST)
        DC_BRAKE_ACTIVE |-> (DC_BRAKE_LEVEL <= LEVEL_MAX && DC_BRAKE_LEVEL % LEVEL_STEP == 0))
        else $error("brake level off the step grid");
    a_rev_freq_gated: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_reg == BR_IDLE && REVERSING && rev_time_eff == TIME_OFF)
        |=> (state_reg != BR_REV))
        else $error("threshold acted with duration disabled");
    a_stop_level_own: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_reg == BR_IDLE && stop_go && !rev_go)
        |=> (DC_BRAKE_LEVEL == $past(norm_level_eff) && !REVERSAL_BRAKE_ACTIVE))
        else $error("stop brake did not use its own level");
    a_inching_map: assert property (@(posedge CLK) disable iff (SYS_RST)
        (sw_sync[0] && INPUT1_FUNCTION_SELECT == FN_INCHING) |=> INCHING_SELECT)
        else $error("inching select not driven from input 1");
    a_speed_search_map: assert property (@(posedge CLK) disable iff (SYS_RST)
        (sw_sync[3] && INPUT4_FUNCTION_SELECT == FN_SPEED_SRCH) |=> SPEED_SEARCH)
        else $error("speed search not driven from input 4");
    a_sixteen_speed: assert property (@(posedge CLK) disable iff (SYS_RST)
        (MULTISPEED_MODE_SELECT == MS_MODE_SIXTEEN && (&ms_mask))
        |=> (!SPEED_CODE[4] && SPEED_CODE[3:0] == $past(sw_sync[3:0])))
        else $error("fifth input leaked into sixteen-speed code");
    a_trip_clear_fall: assert property (@(posedge CLK) disable iff (SYS_RST)
        (FAULT_TRIPPED && !reset_armed_reg && !trip_set) |=> FAULT_TRIPPED)
        else $error("trip cleared without a reset on then off");
    a_pulse_input_two: assert property (@(posedge CLK) disable iff (SYS_RST)
        PULSE_COUNT_IN |-> $past(sw_sync[1]))
        else $error("pulse input not from input 2");

    c_rev_brake_done: cover property (@(posedge CLK) disable iff (SYS_RST)
        REVERSAL_BRAKE_ACTIVE ##1 BRAKE_DONE);
    c_stop_brake: cover property (@(posedge CLK) disable iff (SYS_RST)
        DC_BRAKE_ACTIVE && !REVERSAL_BRAKE_ACTIVE);
    c_trip_cleared: cover property (@(posedge CLK) disable iff (SYS_RST)
        FAULT_TRIPPED ##1 !FAULT_TRIPPED);
    c_sixteen_speed: cover property (@(posedge CLK) disable iff (SYS_RST)
        MULTISPEED_MODE_SELECT == MS_MODE_SIXTEEN && (&ms_mask) && sw_sync[4]);
endmodule
`default_nettype wire

/* File: testbench/rbs_switch_model.sv */
// model of the external switch contacts on the five input terminals
`timescale 1ns/1ps
`default_nettype none
module rbs_switch_model (
    // clock
    input  wire logic       clk,
    // requested contact states and terminal levels
    input  wire logic [4:0] want,
    output logic      [4:0] sw
);
    // contacts settle a cycle after the request, like a debounced switch
    always_ff @(posedge clk) begin
        sw <= want;
    end
endmodule
`default_nettype wire

/* File: testbench/test_reversal_brake_and_input_select.sv */
// self-checking bench for the reversal brake and input select block
`timescale 1ns/1ps
`default_nettype none
module test_reversal_brake_and_input_select import rbs_pkg::*; ;
    logic clk = 0, rst = 1, rev = 0, rs = 0, fe = 0, dca, rba, done, trip;
    logic [4:0] want = 0, sw, spd;
    logic [3:0] s1 = 0, s2 = 0, s3 = 0, s4 = 0, s5 = 0;
    logic [2:0] ms = 0;
    logic [9:0] rf = 10'h064, nf = 10'h032, of = 10'h0C8;
    logic [10:0] rt = 0, nt = 0;
    logic [6:0] rl = 0, nl = 0, lvl;
    logic [14:0] fn;
    logic [3:0] cd [13] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13, 14, 11};
    int err_total = 0, n_checks = 0, k;
    initial forever #5 clk = ~clk;
    rbs_switch_model sm (.clk(clk), .want(want), .sw(sw));
    rbs_reversal_brake_top #(.TICK_CYCLES(4)) dut (.CLK(clk), .SYS_RST(rst),
        .SWITCH_INPUT_1(sw[0]), .SWITCH_INPUT_2(sw[1]), .SWITCH_INPUT_3(sw[2]),
        .SWITCH_INPUT_4(sw[3]), .SWITCH_INPUT_5(sw[4]), .INPUT1_FUNCTION_SELECT(s1),
        .INPUT2_FUNCTION_SELECT(s2), .INPUT3_FUNCTION_SELECT(s3), .INPUT4_FUNCTION_SELECT(s4),
        .INPUT5_FUNCTION_SELECT(s5), .MULTISPEED_MODE_SELECT(ms), .REVERSAL_STOP_FREQ(rf),
        .REVERSAL_BRAKE_TIME(rt), .REVERSAL_BRAKE_LEVEL(rl), .NORMAL_STOP_FREQ(nf),
        .NORMAL_BRAKE_TIME(nt), .NORMAL_BRAKE_LEVEL(nl), .OUTPUT_FREQ(of), .REVERSING(rev),
        .RAMP_STOPPING(rs), .FAULT_EVENT(fe), .DC_BRAKE_ACTIVE(dca), .REVERSAL_BRAKE_ACTIVE(rba),
        .DC_BRAKE_LEVEL(lvl), .BRAKE_DONE(done), .FAULT_TRIPPED(trip), .SPEED_CODE(spd),
        .RESET_LOCK_ACTIVE(fn[0]), .INCHING_SELECT(fn[1]), .EXT_FAULT_STOP(fn[2]),
        .PARAM_LOCK(fn[3]), .COAST_STOP(fn[4]), .FREQ_SOURCE_2ND(fn[5]), .SECOND_CHAR_SET(fn[6]),
        .PID_CANCEL(fn[7]), .THREE_WIRE_STOP(fn[8]), .SPEED_SEARCH(fn[9]), .WINDING_PAUSE(fn[10]),
        .PULSE_COUNT_IN(fn[11]), .FREQ_UP_DOWN(fn[12]), .WIND_LEN_MODE(fn[13]),
        .WIND_LEN_CLEAR(fn[14]));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    // switch levels need model, sync and output register to land
    task automatic sw_set(input logic [4:0] v);
        @(posedge clk) want <= v;
        repeat (6) @(negedge clk);
    endtask
    task automatic t_funcs();
        for (int i = 0; i < 13; i++) begin
            @(posedge clk) s1 <= cd[i];
            sw_set(5'h01);
            chk("fn", i < 11 ? 16'h0001 << i : (i == 11 ? 16'h2000 : 16'h0000), fn);
            sw_set(5'h00);
        end
        // input-specific codes on their own inputs; code 11 on input 1 must stay inert
        @(posedge clk) s2 <= FN_PULSE_UPDN;
        s3 <= FN_WIND_LEN;
        s4 <= FN_SPEED_SRCH;
        s5 <= FN_PULSE_UPDN;
        sw_set(5'h1F);
        chk("fn_own", 16'h5A00, fn);
        sw_set(5'h00);
        @(posedge clk) s1 <= FN_MULTISPEED;
        s2 <= FN_MULTISPEED;
        s3 <= FN_MULTISPEED;
        s4 <= FN_MULTISPEED;
        s5 <= FN_MULTISPEED;
    endtask
    task automatic t_speed();
        @(posedge clk) ms <= MS_MODE_SIXTEEN;
        sw_set(5'h1F);
        chk("spd16", 16'h000F, spd);
        @(posedge clk) ms <= 3'h0;
        sw_set(5'h1F);
        chk("spd", 16'h001F, spd);
        sw_set(5'h00);
    endtask
    task automatic t_fault();
        // the external fault stop pass in t_funcs left a trip behind
        chk("trip_ext", 16'h0001, trip);
        @(posedge clk) s2 <= FN_RESET;
        sw_set(5'h02);
        sw_set(5'h00);
        chk("trip_pre", 16'h0000, trip);
        @(posedge clk) fe <= 1;
        @(posedge clk) fe <= 0;
        sw_set(5'h02);
        chk("trip_on", 16'h0001, trip);
        sw_set(5'h00);
        chk("trip_off", 16'h0000, trip);
    endtask
    // r selects reversal or ordinary stop; t is brake time in 0.1 s ticks
    task automatic t_brake(input logic r, input logic [10:0] t);
        @(posedge clk) rev <= r;
        rs <= !r; rt <= t; nt <= t; rl <= 7'h32; nl <= 7'h14; of <= FREQ_MAX;
        repeat (6) @(negedge clk);
        chk("above", 16'h0000, dca);
        @(posedge clk) of <= 10'h010;
        k = 0;
        while (dca !== 1'b1 && k < 20) begin @(negedge clk); k++; end
        chk("act", {15'h0, t != 0}, dca);
        if (t != 0) begin
            chk("rba", {15'h0, r}, rba);
            chk("lvl", r ? 16'h0032 : 16'h0014, lvl);
            k = 0;
            while (done !== 1'b1 && k < 100) begin @(negedge clk); k++; end
            chk("len", 16'h0001, {15'h0, k >= t * 4 && k <= t * 4 + 2});
        end
        @(posedge clk) rev <= 0;
        rs <= 0; of <= 10'h0C8;
        repeat (4) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200us;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        t_funcs();
        t_speed();
        t_fault();
        t_brake(1, 11'h002);
        t_brake(0, 11'h001);
        t_brake(1, 11'h000);
        stop_test();
    end
endmodule
`default_nettype wire
